//--- include/srea_consts.svh
`ifndef SREA_CONSTS_SVH
`define SREA_CONSTS_SVH
`define SMB_ADDR_HI 5'h0D
`define CMD_RAM_MAX 8'hDF
`define CMD_EE_LO 8'hF8
`define CMD_EE_HI 8'hFB
`define CMD_BLK_WR 8'hFC
`define CMD_BLK_RD 8'hFD
`define CMD_ERASE 8'hFE
`define UPD_CFG 8'h90
`define ERASE_EN_BIT 2
`define BLK_CNT 8'h20
`define PAGE_BYTES 32'h20
`define EE_TOP6 6'h3E
`define RAM_PAGE 8'h00
`define CRC_POLY 8'h07
`define CRC_INIT 8'h00
`define EE_BLANK 8'hFF
`define IDLE_BYTE 8'hFF
`define ERASE_MS 20
`define PROG_US 250
`define TOUT_MS 30
`define CLK_NS 5
`define LNK_NS 64
`endif

//--- include/srea_pkg.sv
package srea_pkg;
	typedef enum logic [1:0] {EV_ADDR, EV_WR, EV_RD, EV_STOP} srea_ev_t;
	typedef enum logic [2:0] {
		T_IDLE, T_CMD, T_D1, T_D2, T_BCNT, T_BDATA, T_PEC, T_RD
	} srea_tst_t;
	typedef enum logic [2:0] {
		L_IDLE, L_RX, L_RXF, L_WAIT, L_ACK, L_TX, L_MACK, L_MACKF
	} srea_lst_t;
	typedef struct packed {
		logic rst1;
		logic rst2;
		logic scl1;
		logic scl2;
		logic sclp;
		logic sda1;
		logic sda2;
		logic sdap;
		logic rsp1;
		logic rsp2;
		srea_lst_t st;
		logic [2:0] bitc;
		logic [7:0] sh;
		logic rw;
		logic first;
		logic mack;
		logic req;
		srea_ev_t kind;
		logic sda_drv;
		logic [31:0] tcnt;
	} srea_link_t;
	typedef struct packed {
		logic rq1;
		logic rq2;
		logic a1s1;
		logic a1s2;
		logic a0s1;
		logic a0s2;
		logic rsp_tgl;
		logic rsp_ack;
		logic [7:0] rsp_byte;
		logic rsp_due;
		srea_tst_t tst;
		logic [7:0] cmd;
		logic [15:0] ptr;
		logic armed;
		logic blk;
		logic [7:0] rdcnt;
		logic [7:0] bcnt;
		logic [7:0] crc;
		logic erasing;
		logic [31:0] ecnt;
		logic [31:0] wcnt;
	} srea_core_t;
endpackage

//--- hw/srea_link.sv
`timescale 1ns/1ps
`include "srea_consts.svh"
module srea_link #(
	parameter int unsigned TOUT_CYC = 1
) (
	input wire logic lnk_clk_in,
	input wire logic rst_in,
	input wire logic scl_in,
	input wire logic sda_in,
	output logic scl_oe_n_out,
	output logic sda_oe_n_out,
	input wire logic rsp_tgl_in,
	input wire logic rsp_ack_in,
	input wire logic [7:0] rsp_byte_in,
	output logic req_tgl_out,
	output srea_pkg::srea_ev_t ev_kind_out,
	output logic [7:0] ev_byte_out
);
	import srea_pkg::*;
	srea_link_t s;
	srea_link_t n;
	logic rise;
	logic fall;
	logic hi;
	always_comb begin
		n = s;
		n.rst1 = rst_in;
		n.rst2 = s.rst1;
		n.scl1 = scl_in;
		n.scl2 = s.scl1;
		n.sclp = s.scl2;
		n.sda1 = sda_in;
		n.sda2 = s.sda1;
		n.sdap = s.sda2;
		n.rsp1 = rsp_tgl_in;
		n.rsp2 = s.rsp1;
		rise = s.scl2 & ~s.sclp;
		fall = ~s.scl2 & s.sclp;
		hi = s.scl2 & s.sclp;
		if (s.st != L_IDLE && s.st != L_WAIT && !s.scl2)
			n.tcnt = s.tcnt + 32'h1;
		else
			n.tcnt = '0;
		case (s.st)
		L_RX: if (rise) begin
			n.sh = {s.sh[6:0], s.sda2};
			n.bitc = s.bitc + 3'h1;
			if (s.bitc == 3'h7)
				n.st = L_RXF;
		end
		L_RXF: if (fall) begin
			n.kind = s.first ? EV_ADDR : EV_WR;
			if (s.first)
				n.rw = s.sh[0];
			n.req = ~s.req;
			n.st = L_WAIT;
		end
		L_WAIT: if (s.rsp2 == s.req) begin
			if (s.kind == EV_STOP) begin
				n.st = L_IDLE;
			end else if (s.kind == EV_RD) begin
				n.sh = rsp_byte_in;
				n.sda_drv = ~rsp_byte_in[7];
				n.st = L_TX;
			end else if (rsp_ack_in) begin
				n.sda_drv = 1'b1;
				n.st = L_ACK;
			end else begin
				n.st = L_IDLE;
			end
		end
		L_ACK: if (fall) begin
			n.first = 1'b0;
			n.sda_drv = 1'b0;
			n.st = L_RX;
			if (s.rw) begin
				n.sh = rsp_byte_in;
				n.sda_drv = ~rsp_byte_in[7];
				n.st = L_TX;
			end
		end
		L_TX: if (fall) begin
			n.sh = {s.sh[6:0], 1'b0};
			n.sda_drv = ~s.sh[6];
			n.bitc = s.bitc + 3'h1;
			if (s.bitc == 3'h7) begin
				n.sda_drv = 1'b0;
				n.st = L_MACK;
			end
		end
		L_MACK: if (rise) begin
			n.mack = ~s.sda2;
			n.st = L_MACKF;
		end
		L_MACKF: if (fall) begin
			n.st = L_IDLE;
			if (s.mack) begin
				n.kind = EV_RD;
				n.req = ~s.req;
				n.st = L_WAIT;
			end
		end
		default: ;
		endcase
		if (s.tcnt >= TOUT_CYC) begin
			n.st = L_IDLE;
			n.sda_drv = 1'b0;
		end
		if (s.st != L_WAIT && hi && s.sdap && !s.sda2) begin
			n.st = L_RX;
			n.first = 1'b1;
			n.bitc = '0;
			n.sda_drv = 1'b0;
		end else if (s.st != L_WAIT && hi && !s.sdap && s.sda2) begin
			n.kind = EV_STOP;
			n.req = ~s.req;
			n.sda_drv = 1'b0;
			n.st = L_WAIT;
		end
		if (s.rst2) begin
			n = '0;
			n.rst1 = rst_in;
			n.rst2 = s.rst1;
			n.scl2 = 1'b1;
			n.sclp = 1'b1;
			n.sda2 = 1'b1;
			n.sdap = 1'b1;
		end
	end
	always_ff @(posedge lnk_clk_in) begin
		s <= n;
	end
	// Hold SCL low while the core has not answered, except after a stop
	assign scl_oe_n_out = ~(s.st == L_WAIT && s.kind != EV_STOP);
	assign sda_oe_n_out = ~s.sda_drv;
	assign req_tgl_out = s.req;
	assign ev_kind_out = s.kind;
	assign ev_byte_out = s.sh;
	AST_TOUT_ABORT: assert property (@(posedge lnk_clk_in)
		disable iff (s.rst2)
		s.tcnt >= TOUT_CYC && s.st != L_WAIT && !s.scl2
		|=> s.st == L_IDLE && !s.sda_drv)
		else $error("Timeout did not abandon the transfer");
	AST_FLUSH_RELEASE: assert property (@(posedge lnk_clk_in)
		disable iff (s.rst2)
		s.st == L_MACKF && fall && !s.mack |=> sda_oe_n_out)
		else $error("SDA still driven after missing master ack");
endmodule

//--- hw/srea_top.sv
`timescale 1ns/1ps
`include "srea_consts.svh"
// Notes on behaviour
// - Send byte with a RAM command loads the address pointer.
// - Command 0xFE erases the set page, only with bit 2 of 0x90 set.
// - Erase starts as soon as the command byte arrives; stop may follow.
// - Every access during the 20 ms erase is not acknowledged.
// - Write byte with command 0x00-0xDF stores data at that RAM location.
// - Command 0xF8-0xFB plus one data byte sets the 16-bit EEPROM pointer.
// - Erase page comes from the top five of the ten pointer address bits (9:5).
// - Write word to EEPROM: first byte address low, second byte data.
// - Block write: 0xFC, count up to 32, data at the set address.
// - Each EEPROM byte takes 250 us; SCL is stretched meanwhile.
// - Receive byte returns the pointed location; master nacks and stops.
// - Block read: 0xFD, repeated start, read address, data from pointer.
// - Block read sends count 0x20 then exactly 32 data bytes.
// - An optional check byte may follow writes and block reads.
// - The check byte is CRC-8 with polynomial x^8+x^2+x+1.
// - Own write address, command and data bytes are acknowledged.
// - Slave address is 01101 followed by the two select pin levels.
// - Up to 9 SCL pulses make the device release SDA.
// - SCL low for about 30 ms abandons the transaction.
module srea_top #(
	parameter int unsigned ERASE_CYC = `ERASE_MS * 1000000 / `CLK_NS,
	parameter int unsigned PROG_CYC = `PROG_US * 1000 / `CLK_NS,
	parameter int unsigned TOUT_CYC = `TOUT_MS * 1000000 / `LNK_NS
) (
	input wire logic clk_in,
	input wire logic rst_in,
	input wire logic lnk_clk_in,
	input wire logic scl_in,
	output logic scl_out,
	output logic scl_oe_n_out,
	input wire logic sda_in,
	output logic sda_out,
	output logic sda_oe_n_out,
	input wire logic address_select_high_pin_in,
	input wire logic address_select_low_pin_in
);
	import srea_pkg::*;
	srea_core_t s;
	srea_core_t n;
	logic [7:0] ram_mem [0:255];
	logic [7:0] ee_mem [0:1023];
	logic ram_we;
	logic [7:0] ram_wa;
	logic [7:0] ram_wd;
	logic ee_we;
	logic [9:0] ee_wa;
	logic [7:0] ee_wd;
	logic [7:0] rd_byte;
	logic [6:0] own;
	logic pend;
	logic erase_en;
	logic ptr_ee;
	logic cmd_ee;
	logic req_tgl;
	srea_ev_t ev_kind;
	logic [7:0] ev_byte;

	function automatic logic [7:0] crc8(input logic [7:0] c,
		input logic [7:0] d);
		logic [7:0] r;
		r = c;
		for (int i = 7; i >= 0; i--) begin
			if (r[7] ^ d[i])
				r = {r[6:0], 1'b0} ^ `CRC_POLY;
			else
				r = {r[6:0], 1'b0};
		end
		return r;
	endfunction

	srea_link #(
		.TOUT_CYC(TOUT_CYC)
	) u_link (
		.lnk_clk_in(lnk_clk_in),
		.rst_in(rst_in),
		.scl_in(scl_in),
		.sda_in(sda_in),
		.scl_oe_n_out(scl_oe_n_out),
		.sda_oe_n_out(sda_oe_n_out),
		.rsp_tgl_in(s.rsp_tgl),
		.rsp_ack_in(s.rsp_ack),
		.rsp_byte_in(s.rsp_byte),
		.req_tgl_out(req_tgl),
		.ev_kind_out(ev_kind),
		.ev_byte_out(ev_byte)
	);

	assign scl_out = 1'b0;
	assign sda_out = 1'b0;
	assign own = {`SMB_ADDR_HI, s.a1s2, s.a0s2};
	assign erase_en = ram_mem[`UPD_CFG][`ERASE_EN_BIT];
	assign ptr_ee = s.ptr[15:10] == `EE_TOP6;
	assign cmd_ee = s.cmd >= `CMD_EE_LO && s.cmd <= `CMD_EE_HI;
	assign pend = (s.rq2 != s.rsp_tgl) && !s.rsp_due;

	// Byte at the pointer, RAM or EEPROM
	always_comb begin
		rd_byte = `IDLE_BYTE;
		if (s.ptr[15:8] == `RAM_PAGE)
			rd_byte = ram_mem[s.ptr[7:0]];
		else if (ptr_ee)
			rd_byte = ee_mem[s.ptr[9:0]];
	end

	always_comb begin
		n = s;
		ram_we = 1'b0;
		ram_wa = s.cmd;
		ram_wd = ev_byte;
		ee_we = 1'b0;
		ee_wa = s.ptr[9:0];
		// Programming only clears bits of an erased cell
		ee_wd = ev_byte & ee_mem[s.ptr[9:0]];
		n.rq1 = req_tgl;
		n.rq2 = s.rq1;
		n.a1s1 = address_select_high_pin_in;
		n.a1s2 = s.a1s1;
		n.a0s1 = address_select_low_pin_in;
		n.a0s2 = s.a0s1;
		// Answer is held back while a cell programs
		if (s.wcnt != 32'h0) begin
			n.wcnt = s.wcnt - 32'h1;
		end else if (s.rsp_due) begin
			n.rsp_due = 1'b0;
			n.rsp_tgl = ~s.rsp_tgl;
		end
		if (s.erasing) begin
			if (s.ecnt < `PAGE_BYTES) begin
				ee_we = 1'b1;
				ee_wa = {s.ptr[9:5], s.ecnt[4:0]};
				ee_wd = `EE_BLANK;
			end
			n.ecnt = s.ecnt + 32'h1;
			if (s.ecnt == ERASE_CYC - 1)
				n.erasing = 1'b0;
		end
		if (pend) begin
			n.rsp_due = 1'b1;
			n.rsp_ack = 1'b1;
			n.rsp_byte = `IDLE_BYTE;
			case (ev_kind)
			EV_ADDR: begin
				if (ev_byte[7:1] != own || s.erasing) begin
					n.rsp_ack = 1'b0;
					n.tst = T_IDLE;
					n.armed = 1'b0;
				end else if (!ev_byte[0]) begin
					n.tst = T_CMD;
					n.armed = 1'b0;
					n.crc = crc8(`CRC_INIT, ev_byte);
				end else if (s.armed) begin
					n.blk = 1'b1;
					n.rdcnt = '0;
					n.rsp_byte = `BLK_CNT;
					n.crc = crc8(crc8(s.crc, ev_byte), `BLK_CNT);
					n.tst = T_RD;
					n.armed = 1'b0;
				end else begin
					n.blk = 1'b0;
					n.rsp_byte = rd_byte;
					n.tst = T_RD;
				end
			end
			EV_RD: begin
				if (s.blk && s.rdcnt < `BLK_CNT) begin
					n.rsp_byte = rd_byte;
					n.crc = crc8(s.crc, rd_byte);
					n.ptr = s.ptr + 16'h1;
					n.rdcnt = s.rdcnt + 8'h1;
				end else if (s.blk && s.rdcnt == `BLK_CNT) begin
					n.rsp_byte = s.crc;
					n.rdcnt = s.rdcnt + 8'h1;
				end
			end
			EV_STOP: begin
				n.tst = T_IDLE;
				n.armed = 1'b0;
			end
			default: begin
				n.crc = crc8(s.crc, ev_byte);
				case (s.tst)
				T_CMD: begin
					n.cmd = ev_byte;
					n.tst = T_D1;
					if (ev_byte <= `CMD_RAM_MAX) begin
						n.ptr = {`RAM_PAGE, ev_byte};
					end else if (ev_byte == `CMD_BLK_WR) begin
						n.tst = T_BCNT;
					end else if (ev_byte == `CMD_BLK_RD) begin
						n.armed = 1'b1;
						n.tst = T_PEC;
					end else if (ev_byte == `CMD_ERASE) begin
						n.tst = T_PEC;
						if (erase_en) begin
							n.erasing = 1'b1;
							n.ecnt = '0;
						end
					end
				end
				T_D1: begin
					n.tst = T_PEC;
					if (s.cmd <= `CMD_RAM_MAX) begin
						ram_we = 1'b1;
					end else if (cmd_ee) begin
						n.ptr = {s.cmd, ev_byte};
						n.tst = T_D2;
					end
				end
				T_D2: begin
					ee_we = 1'b1;
					n.wcnt = PROG_CYC;
					n.tst = T_PEC;
				end
				T_BCNT: begin
					n.bcnt = ev_byte;
					n.tst = (ev_byte == 8'h00) ? T_PEC : T_BDATA;
				end
				T_BDATA: begin
					if (ptr_ee) begin
						ee_we = 1'b1;
						n.wcnt = PROG_CYC;
					end else if (s.ptr[15:8] == `RAM_PAGE) begin
						ram_we = 1'b1;
						ram_wa = s.ptr[7:0];
					end
					n.ptr = s.ptr + 16'h1;
					n.bcnt = s.bcnt - 8'h1;
					if (s.bcnt == 8'h01)
						n.tst = T_PEC;
				end
				default: ;
				endcase
			end
			endcase
		end
		if (rst_in)
			n = '0;
	end

	always_ff @(posedge clk_in) begin
		s <= n;
	end

	always_ff @(posedge clk_in) begin
		if (ram_we)
			ram_mem[ram_wa] <= ram_wd;
		if (ee_we)
			ee_mem[ee_wa] <= ee_wd;
	end

	AST_ERASE_NACK: assert property (@(posedge clk_in)
		disable iff (rst_in)
		pend && ev_kind == EV_ADDR && s.erasing |=> !s.rsp_ack)
		else $error("Access during erase was acknowledged");
	AST_ERASE_CAUSE: assert property (@(posedge clk_in)
		disable iff (rst_in)
		$rose(s.erasing) |-> $past(pend) && $past(erase_en)
		&& $past(ev_byte) == `CMD_ERASE)
		else $error("Erase started without command or enable");
	AST_ERASE_START: assert property (@(posedge clk_in)
		disable iff (rst_in)
		pend && ev_kind == EV_WR && s.tst == T_CMD
		&& ev_byte == `CMD_ERASE && erase_en
		|=> s.erasing && s.rsp_ack && s.ecnt == 32'h0)
		else $error("Erase did not start on the command byte");
	AST_ERASE_OFF: assert property (@(posedge clk_in)
		disable iff (rst_in)
		pend && ev_kind == EV_WR && s.tst == T_CMD
		&& ev_byte == `CMD_ERASE && !erase_en && !s.erasing
		|=> !s.erasing && s.rsp_ack ##1 !ee_we)
		else $error("Disabled erase altered the EEPROM");
	AST_ERASE_PAGE: assert property (@(posedge clk_in)
		disable iff (rst_in)
		s.erasing && ee_we
		|-> ee_wa[9:5] == s.ptr[9:5] && ee_wd == `EE_BLANK)
		else $error("Erase wrote outside the selected page");
	AST_RAM_WRITE: assert property (@(posedge clk_in)
		disable iff (rst_in)
		pend && ev_kind == EV_WR && s.tst == T_D1
		&& s.cmd <= `CMD_RAM_MAX
		|-> ram_we && ram_wa == s.cmd && ram_wd == ev_byte)
		else $error("Write byte did not reach its RAM location");
	AST_EE_POINTER: assert property (@(posedge clk_in)
		disable iff (rst_in)
		pend && ev_kind == EV_WR && s.tst == T_D1 && cmd_ee
		|=> s.ptr == {$past(s.cmd), $past(ev_byte)} && s.tst == T_D2)
		else $error("EEPROM pointer not formed from command and data");
	AST_EE_PROGRAM: assert property (@(posedge clk_in)
		disable iff (rst_in)
		pend && ev_kind == EV_WR && s.tst == T_D2
		|-> ee_we && ee_wa == s.ptr[9:0])
		else $error("Second data byte was not programmed");
	AST_PROG_HOLD: assert property (@(posedge clk_in)
		disable iff (rst_in)
		$changed(s.rsp_tgl) |-> $past(s.wcnt) == 32'h0)
		else $error("Answer released while a cell was programming");
	AST_CMD_ACK: assert property (@(posedge clk_in)
		disable iff (rst_in)
		pend && ev_kind == EV_WR && s.tst != T_IDLE |=> s.rsp_ack)
		else $error("Write byte was not acknowledged");
	AST_OWN_ADDR: assert property (@(posedge clk_in)
		disable iff (rst_in)
		pend && ev_kind == EV_ADDR && ev_byte[7:1] != own
		|=> !s.rsp_ack)
		else $error("Foreign slave address was acknowledged");
	AST_BLK_COUNT: assert property (@(posedge clk_in)
		disable iff (rst_in)
		pend && ev_kind == EV_ADDR && ev_byte[0] && s.armed
		&& ev_byte[7:1] == own && !s.erasing
		|=> s.rsp_byte == `BLK_CNT && s.blk && s.rdcnt == 8'h00)
		else $error("Block read did not open with the count byte");
	AST_PTR_STEP: assert property (@(posedge clk_in)
		disable iff (rst_in)
		pend && ev_kind == EV_RD && s.blk && s.rdcnt < `BLK_CNT
		|=> s.ptr == $past(s.ptr) + 16'h1)
		else $error("Pointer did not advance in block read");
	AST_PEC_BYTE: assert property (@(posedge clk_in)
		disable iff (rst_in)
		pend && ev_kind == EV_RD && s.blk && s.rdcnt == `BLK_CNT
		|=> s.rsp_byte == $past(s.crc))
		else $error("Check byte does not follow the last data byte");
	AST_RECV_BYTE: assert property (@(posedge clk_in)
		disable iff (rst_in)
		pend && ev_kind == EV_ADDR && ev_byte[0] && !s.armed
		&& ev_byte[7:1] == own && !s.erasing
		|=> s.rsp_byte == $past(rd_byte) && !s.blk)
		else $error("Receive byte returned the wrong location");
endmodule

//--- verif/srea_master.sv
`timescale 1ns/1ps
module srea_master (
	input wire logic scl_in,
	input wire logic sda_in,
	output logic scl_low_out,
	output logic sda_low_out
);
	int stretch_ns;
	initial begin
		scl_low_out = 1'b0;
		sda_low_out = 1'b0;
		stretch_ns = 0;
	end
	// One bit slot, entered with SCL low; samples SDA late in the high
	task automatic put_bit(input logic v, output logic s);
		int n;
		n = 0;
		#128 sda_low_out = ~v;
		#192 scl_low_out = 1'b0;
		while (scl_in !== 1'b1 && n < 4000) begin // Wait out stretch
			#8 n++;
		end
		stretch_ns = n * 8;
		#192 s = sda_in;
		scl_low_out = 1'b1;
	endtask
	// Start or repeated start
	task automatic start();
		#128 sda_low_out = 1'b0;
		#192 scl_low_out = 1'b0;
		#256 sda_low_out = 1'b1;
		#256 scl_low_out = 1'b1;
	endtask
	task automatic stop();
		#128 sda_low_out = 1'b1;
		#192 scl_low_out = 1'b0;
		#256 sda_low_out = 1'b0;
		#256;
	endtask
	task automatic wbyte(input logic [7:0] b, output logic ack);
		logic s;
		for (int i = 7; i >= 0; i--) begin
			put_bit(b[i], s);
		end
		put_bit(1'b1, s);
		ack = ~s;
	endtask
	task automatic rbyte(input logic mack, output logic [7:0] b);
		logic s;
		for (int i = 7; i >= 0; i--) begin
			put_bit(1'b1, s);
			b[i] = s;
		end
		put_bit(~mack, s);
	endtask
endmodule

//--- verif/testbench.sv
`timescale 1ns/1ps
module testbench;
	logic clk_in, lnk_clk_in, rst_in, sel_hi, sel_lo;
	logic scl_out, scl_oe_n_out, sda_out, sda_oe_n_out;
	logic m_scl_low, m_sda_low, scl, sda, ok;
	logic [6:0] dev;
	int miscompares = 0;
	int compares = 0;
	assign scl = ~(m_scl_low | ~scl_oe_n_out);
	assign sda = ~(m_sda_low | ~sda_oe_n_out);
	initial begin
		clk_in = 1'b0;
		forever #2.5 clk_in = ~clk_in;
	end
	initial begin
		lnk_clk_in = 1'b0;
		#7.3;
		forever #32 lnk_clk_in = ~lnk_clk_in;
	end
	srea_top #(.ERASE_CYC(2000), .PROG_CYC(200), .TOUT_CYC(150)) dut (
		.clk_in(clk_in), .rst_in(rst_in), .lnk_clk_in(lnk_clk_in),
		.scl_in(scl), .scl_out(scl_out), .scl_oe_n_out(scl_oe_n_out),
		.sda_in(sda), .sda_out(sda_out), .sda_oe_n_out(sda_oe_n_out),
		.address_select_high_pin_in(sel_hi),
		.address_select_low_pin_in(sel_lo)
	);
	srea_master m (.scl_in(scl), .sda_in(sda),
		.scl_low_out(m_scl_low), .sda_low_out(m_sda_low));
	task automatic check(input string what, input logic [15:0] seen,
		input logic [15:0] exp);
		compares++;
		if (seen !== exp) begin
			miscompares++;
			$display("[ERR] %s expected %h seen %h", what, exp, seen);
		end
	endtask
	task automatic conclude();
		$display("compares %0d miscompares %0d", compares, miscompares);
		if (miscompares == 0 && compares > 0) begin
			$display("NO MISMATCHES");
		end else begin
			$display("MISMATCHES SEEN");
		end
		$finish;
	endtask
	function automatic logic [7:0] crc8(input logic [7:0] c,
		input logic [7:0] d);
		logic [7:0] r;
		r = c ^ d;
		for (int k = 0; k < 8; k++) begin
			r = r[7] ? ({r[6:0], 1'b0} ^ 8'h07) : {r[6:0], 1'b0};
		end
		return r;
	endfunction
	task automatic set_pins(input logic h, input logic l);
		@(posedge clk_in);
		#1;
		sel_hi = h;
		sel_lo = l;
		dev = {5'h0D, h, l};
		#200;
	endtask
	task automatic wr(input logic [7:0] b);
		logic a;
		m.wbyte(b, a);
		ok = ok & a;
	endtask
	task automatic send(input logic [7:0] cmd, input int n,
		input logic [7:0] d0, input logic [7:0] d1);
		ok = 1'b1;
		m.start();
		wr({dev, 1'b0});
		wr(cmd);
		if (n > 0) begin
			wr(d0);
		end
		if (n > 1) begin
			wr(d1);
		end
		m.stop();
	endtask
	task automatic recv(output logic [7:0] b);
		ok = 1'b1;
		m.start();
		wr({dev, 1'b1});
		m.rbyte(1'b0, b); // Master nacks the single byte
		m.stop();
	endtask
	task automatic t_address();
		logic a;
		for (int i = 0; i < 4; i++) begin
			set_pins(i[1], i[0]);
			m.start();
			m.wbyte({dev, 1'b0}, a);
			m.stop();
			check("addr_ack", a, 1);
		end
		m.start();
		m.wbyte({5'h0D, ~dev[1:0], 1'b0}, a);
		m.stop();
		check("addr_pins_wrong", a, 0);
		m.start();
		m.wbyte({5'h0C, dev[1:0], 1'b0}, a);
		m.stop();
		check("addr_upper_wrong", a, 0);
		check("scl_out", scl_out, 0);
		check("sda_out", sda_out, 0);
		$display("test address done");
	endtask
	task automatic t_ram();
		logic [7:0] b;
		send(8'h90, 1, 8'h04, 8'h00);
		check("ram_wr_ack", ok, 1);
		check("ram_stretch_short", m.stretch_ns < 600, 1);
		send(8'hDF, 1, 8'hA3, 8'h00);
		check("ram_top_ack", ok, 1);
		send(8'hDF, 0, 8'h00, 8'h00);
		check("send_byte_ack", ok, 1);
		recv(b);
		check("recv_ram", b, 8'hA3);
		$display("test ram done");
	endtask
	task automatic t_eeprom();
		logic [7:0] exp_d [32];
		logic [7:0] crc, b;
		logic a;
		send(8'hF9, 1, 8'h47, 8'h00);
		check("ee_ptr_ack", ok, 1);
		send(8'hFE, 0, 8'h00, 8'h00); // Stop right after the command
		m.start();
		m.wbyte({dev, 1'b0}, a);
		m.stop();
		check("nack_erasing", a, 0);
		#12000;
		send(8'hF9, 2, 8'h5F, 8'h3C);
		check("ee_prog_ack", ok, 1);
		check("ee_stretch_long", m.stretch_ns > 600, 1);
		send(8'hF9, 1, 8'h40, 8'h00);
		ok = 1'b1;
		m.start();
		wr({dev, 1'b0});
		wr(8'hFC);
		wr(8'h02); // Short block inside one erased page
		wr(8'hA5);
		wr(8'h5A);
		m.stop();
		check("blk_wr_ack", ok, 1);
		check("blk_stretch", m.stretch_ns > 600, 1);
		send(8'hF9, 1, 8'h40, 8'h00);
		for (int i = 0; i < 32; i++) begin
			exp_d[i] = 8'hFF;
		end
		exp_d[0] = 8'hA5;
		exp_d[1] = 8'h5A;
		exp_d[31] = 8'h3C;
		ok = 1'b1;
		m.start();
		wr({dev, 1'b0});
		wr(8'hFD);
		m.start();
		wr({dev, 1'b1});
		crc = crc8(crc8(crc8(8'h00, {dev, 1'b0}), 8'hFD), {dev, 1'b1});
		m.rbyte(1'b1, b);
		check("blk_count", b, 8'h20);
		crc = crc8(crc, 8'h20);
		for (int i = 0; i < 32; i++) begin
			m.rbyte(1'b1, b);
			check("blk_data", b, exp_d[i]);
			crc = crc8(crc, exp_d[i]);
		end
		m.rbyte(1'b0, b); // Master nacks the check byte
		m.stop();
		check("blk_pec", b, crc);
		check("blk_rd_ack", ok, 1);
		$display("test eeprom done");
	endtask
	task automatic t_timeout();
		logic a;
		m.start();
		m.wbyte({dev, 1'b0}, a);
		check("to_addr_ack", a, 1);
		#12000;
		m.wbyte(8'h10, a);
		check("nack_after_timeout", a, 0);
		m.stop();
		$display("test timeout done");
	endtask
	task automatic t_erase_off();
		logic [7:0] b;
		send(8'h90, 1, 8'h00, 8'h00);
		send(8'hF9, 1, 8'h40, 8'h00);
		send(8'hFE, 0, 8'h00, 8'h00);
		check("erase_off_ack", ok, 1);
		recv(b);
		check("erase_off_recv_ack", ok, 1);
		check("erase_off_data", b, 8'hA5);
		$display("test erase disabled done");
	endtask
	initial begin
		rst_in = 1'b1;
		sel_hi = 1'b0;
		sel_lo = 1'b0;
		dev = 7'h34;
		ok = 1'b0;
		repeat (12) @(posedge clk_in);
		#1 rst_in = 1'b0;
		repeat (10) @(posedge lnk_clk_in);
		t_address();
		set_pins(1'b0, 1'b1);
		t_ram();
		t_eeprom();
		t_timeout();
		t_erase_off();
		conclude();
	end
	initial begin
		#495000;
		miscompares++;
		conclude();
	end
endmodule
